// >>> rtl/dcr_pkg.sv
`default_nettype none
package dcr_pkg;

   // write frame field positions
   localparam int WB_ADDR_HI = 15;
   localparam int WB_ADDR_LO = 13;
   localparam int WB_RW      = 12;
   localparam int WB_RNG_HI  = 10;
   localparam int WB_RNG_LO  = 7;
   localparam int WB_CLEAR_LEVEL_SELECT  = 6;
   localparam int WB_OUTPUT_ON   = 5;
   localparam int WB_SENSE_RESISTOR_SELECT    = 4;
   localparam int WB_CLEAR   = 3;
   localparam int WB_SRST    = 2;

   // frame lengths and readback timing, in serial clock edges
   localparam logic [4:0] FRAME_PLAIN  = 5'h10;
   localparam logic [4:0] FRAME_CRC    = 5'h18;
   localparam logic [4:0] HDR_LAST_BIT = 5'h03;
   localparam logic [4:0] READ_START   = 5'h04;
   localparam logic [4:0] CNT_MAX      = 5'h1F;

   localparam logic [7:0] CRC_POLY  = 8'h07;
   localparam logic [1:0] RB_FIXED  = 2'h2;

   // values after reset
   localparam logic [3:0]  RANGE_RST    = 4'h0;
   localparam logic        CLEAR_LEVEL_SELECT_RST   = 1'b0;
   localparam logic        OUTPUT_ON_RST    = 1'b0;
   localparam logic        SENSE_RESISTOR_SELECT_RST     = 1'b0;
   localparam logic [15:0] PIN_SYNC_RST = 16'h4000;

   typedef enum logic [3:0] {
      RNG_NONE, RNG_I4_20, RNG_I0_20, RNG_I0_24, RNG_V0_5, RNG_V0_10,
      RNG_V0_6, RNG_V0_12, RNG_V0_40, RNG_V0_44, RNG_I3P92_20P4,
      RNG_I0_20P4, RNG_I0_24P5
   } dcr_range_t;

   typedef struct packed {
      dcr_range_t range;
      logic       internal_res;
      logic       output_on;
      logic       clear_mid;
      logic       clear_pulse;
   } dcr_drive_t;

   typedef struct packed {
      logic over_temp;
      logic loop_open;
      logic volt_short;
   } dcr_fault_t;

   // resistor select and range code to output range
   function automatic dcr_range_t dcr_decode(input logic       sense_resistor_select,
                                             input logic [3:0] code);
      case ({sense_resistor_select, code})
         5'h00, 5'h10: dcr_decode = RNG_I4_20;
         5'h01, 5'h11: dcr_decode = RNG_I0_20;
         5'h02, 5'h12: dcr_decode = RNG_I0_24;
         5'h05, 5'h15: dcr_decode = RNG_V0_5;
         5'h06, 5'h16: dcr_decode = RNG_V0_10;
         5'h09, 5'h19: dcr_decode = RNG_V0_6;
         5'h0A, 5'h1A: dcr_decode = RNG_V0_12;
         5'h0E:        dcr_decode = RNG_V0_40;
         5'h0F:        dcr_decode = RNG_V0_44;
         5'h1D:        dcr_decode = RNG_I3P92_20P4;
         5'h1E:        dcr_decode = RNG_I0_20P4;
         5'h1F:        dcr_decode = RNG_I0_24P5;
         default:      dcr_decode = RNG_NONE;
      endcase
   endfunction

endpackage
`default_nettype wire

// >>> rtl/dcr_driver_config.sv
`timescale 1ns/100ps
`default_nettype none
module dcr_driver_config (
   input  wire logic              clock,
   input  wire logic              sys_rst,
   input  wire logic              sclk_pin,
   input  wire logic              frame_sync_n_pin,
   input  wire logic              sdi_pin,
   output logic                   sdo_out,
   output logic                   sdo_oe,
   input  wire logic [2:0]        addr_strap,
   input  wire logic              pin_strap_mode,
   input  wire logic [3:0]        range_code_pins,
   input  wire logic              sense_resistor_pin,
   input  wire dcr_pkg::dcr_fault_t fault_in,
   output dcr_pkg::dcr_drive_t    drive,
   output logic                   alarm_n_out,
   output logic                   alarm_n_oe,
   output logic                   loop_open_alarm_n_out,
   output logic                   loop_open_alarm_n_oe,
   output logic                   volt_short_alarm_n_out,
   output logic                   volt_short_alarm_n_oe,
   output logic                   temp_alarm_n_out,
   output logic                   temp_alarm_n_oe
);
   import dcr_pkg::*;

   // pin synchronisers
   logic [15:0] pin_meta;
   logic [15:0] pin_sync;
   logic        sclk_q;
   logic        sync_n_q;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         pin_meta <= PIN_SYNC_RST;
         pin_sync <= PIN_SYNC_RST;
      end else begin
         pin_meta <= {sclk_pin, frame_sync_n_pin, sdi_pin, addr_strap,
                      pin_strap_mode, range_code_pins, sense_resistor_pin,
                      1'b0, fault_in};
         pin_sync <= pin_meta;
      end
   end

   wire        sclk_s  = pin_sync[15];
   wire        sync_n_s = pin_sync[14];
   wire        sdi_s   = pin_sync[13];
   wire [2:0]  addr_s  = pin_sync[12:10];
   wire        hw_mode = pin_sync[9];
   wire [3:0]  rng_pin = pin_sync[8:5];
   wire        sense_resistor_select_pin = pin_sync[4];
   dcr_fault_t flt_s;
   assign flt_s = pin_sync[2:0];

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         sclk_q   <= 1'b0;
         sync_n_q <= 1'b1;
      end else begin
         sclk_q   <= sclk_s;
         sync_n_q <= sync_n_s;
      end
   end

   // serial frame edges; the serial port is idle in strap mode
   wire in_frame  = ~sync_n_s & ~hw_mode;
   wire sclk_rise = sclk_s & ~sclk_q & in_frame;
   wire sync_fall = ~sync_n_s & sync_n_q;
   wire sync_rise = sync_n_s & ~sync_n_q;

   // frame registers
   logic [23:0] shreg;
   logic [4:0]  bit_cnt;
   logic [7:0]  crc;
   logic        rd_sel;
   logic        sdo_q;
   logic        sdo_oe_q;
   logic [14:0] obuf;

   // control and status registers
   logic [3:0]  range_q;
   logic        clear_level_select_q;
   logic        output_on_q;
   logic        sense_resistor_select_q;
   logic        crc_err;
   logic        clear_pulse_q;

   function automatic logic [7:0] crc8_step(input logic [7:0] c,
                                            input logic       b);
      crc8_step = {c[6:0], 1'b0} ^ ((c[7] ^ b) ? CRC_POLY : 8'h00);
   endfunction

   wire [23:0] next_shreg = {shreg[22:0], sdi_s};
   wire [7:0]  next_crc   = crc8_step(crc, sdi_s);
   wire [4:0]  next_cnt   = (bit_cnt == CNT_MAX) ? bit_cnt
                                                 : bit_cnt + 5'h01;

   // header decode on the fourth edge
   wire rd_hit = sclk_rise && (bit_cnt == HDR_LAST_BIT) &&
                 (next_shreg[3:1] == addr_s) && next_shreg[0];

   // readback word built from control and live status
   wire [15:0] rb_word = {addr_s, RB_FIXED, range_q, clear_level_select_q, output_on_q,
                          sense_resistor_select_q, crc_err, flt_s.over_temp,
                          flt_s.loop_open, flt_s.volt_short};

   wire rb_load  = sclk_rise && rd_sel && (bit_cnt == READ_START);
   wire rb_shift = sclk_rise && rd_sel && (bit_cnt > READ_START);

   // write frame decode at frame-sync rise
   wire        frame16 = (bit_cnt == FRAME_PLAIN);
   wire        frame24 = (bit_cnt == FRAME_CRC);
   wire [15:0] wword   = frame24 ? shreg[23:8] : shreg[15:0];
   wire        addr_ok = (wword[WB_ADDR_HI:WB_ADDR_LO] == addr_s) &&
                         !wword[WB_RW];
   wire        wr_end  = sync_rise && !hw_mode && !rd_sel && addr_ok;
   wire        crc_ok  = (crc == 8'h00);
   wire        do_apply = wr_end && (frame16 || (frame24 && crc_ok));
   wire        crc_fail = wr_end && frame24 && !crc_ok;
   wire        soft_rst = do_apply && wword[WB_SRST];

   always_ff @(posedge clock) begin
      if (sys_rst || sync_fall) begin
         shreg   <= 24'h000000;
         bit_cnt <= 5'h00;
         crc     <= 8'h00;
      end else if (sclk_rise) begin
         shreg   <= next_shreg;
         bit_cnt <= next_cnt;
         crc     <= next_crc;
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst || sync_rise || sync_fall) begin
         rd_sel <= 1'b0;
      end else if (rd_hit) begin
         rd_sel <= 1'b1;
      end
   end

   // data out shifter; floats outside an addressed read
   always_ff @(posedge clock) begin
      if (sys_rst || sync_rise) begin
         sdo_oe_q <= 1'b0;
         sdo_q    <= 1'b0;
         obuf     <= 15'h0000;
      end else if (rb_load) begin
         sdo_oe_q <= 1'b1;
         sdo_q    <= rb_word[15];
         obuf     <= rb_word[14:0];
      end else if (rb_shift) begin
         sdo_q    <= obuf[14];
         obuf     <= {obuf[13:0], 1'b0};
      end
   end

   assign sdo_out = sdo_q;
   assign sdo_oe  = sdo_oe_q;

   // control register writes
   always_ff @(posedge clock) begin
      if (sys_rst || soft_rst) begin
         range_q  <= RANGE_RST;
         clear_level_select_q <= CLEAR_LEVEL_SELECT_RST;
         output_on_q  <= OUTPUT_ON_RST;
         sense_resistor_select_q   <= SENSE_RESISTOR_SELECT_RST;
      end else if (do_apply) begin
         range_q  <= wword[WB_RNG_HI:WB_RNG_LO];
         clear_level_select_q <= wword[WB_CLEAR_LEVEL_SELECT];
         output_on_q  <= wword[WB_OUTPUT_ON];
         sense_resistor_select_q   <= wword[WB_SENSE_RESISTOR_SELECT];
      end
   end

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         clear_pulse_q <= 1'b0;
      end else begin
         clear_pulse_q <= do_apply && wword[WB_CLEAR];
      end
   end

   // checksum error latches; a new failure wins over the read clear
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         crc_err <= 1'b0;
      end else begin
         crc_err <= crc_fail | (crc_err & ~rb_load);
      end
   end

   // drive outputs to the analog stage
   dcr_drive_t next_drive;
   always_comb begin
      next_drive.range        = hw_mode ? dcr_decode(sense_resistor_select_pin, rng_pin)
                                        : dcr_decode(sense_resistor_select_q, range_q);
      next_drive.internal_res = hw_mode ? sense_resistor_select_pin : sense_resistor_select_q;
      next_drive.output_on    = hw_mode | output_on_q;
      next_drive.clear_mid    = clear_level_select_q;
      next_drive.clear_pulse  = clear_pulse_q;
   end

   // alarm pins; all open-drain, drive low when enabled
   wire any_fault = flt_s.over_temp | flt_s.loop_open | flt_s.volt_short;
   logic alarm_oe_q;
   logic loop_oe_q;
   logic volt_oe_q;
   logic temp_oe_q;

   always_ff @(posedge clock) begin
      if (sys_rst) begin
         drive      <= '0;
         alarm_oe_q <= 1'b0;
         loop_oe_q  <= 1'b0;
         volt_oe_q  <= 1'b0;
         temp_oe_q  <= 1'b0;
      end else begin
         drive      <= next_drive;
         alarm_oe_q <= ~hw_mode & (any_fault | crc_err);
         loop_oe_q  <= hw_mode & flt_s.loop_open;
         volt_oe_q  <= hw_mode & flt_s.volt_short;
         temp_oe_q  <= hw_mode & flt_s.over_temp;
      end
   end

   assign alarm_n_out            = 1'b0;
   assign alarm_n_oe             = alarm_oe_q;
   assign loop_open_alarm_n_out  = 1'b0;
   assign loop_open_alarm_n_oe   = loop_oe_q;
   assign volt_short_alarm_n_out = 1'b0;
   assign volt_short_alarm_n_oe  = volt_oe_q;
   assign temp_alarm_n_out       = 1'b0;
   assign temp_alarm_n_oe        = temp_oe_q;

   // checks
   chk_sdo_float_sync: assert property (
      @(posedge clock) disable iff (sys_rst)
      sync_rise |=> !sdo_oe)
      else $error("data out not floated after frame-sync rise");

   chk_sdo_first_bit: assert property (
      @(posedge clock) disable iff (sys_rst)
      rb_load |=> sdo_oe && (sdo_out == $past(rb_word[15])))
      else $error("first readback bit wrong at fifth edge");

   chk_sdo_only_read: assert property (
      @(posedge clock) disable iff (sys_rst)
      $rose(sdo_oe) |-> $past(rd_sel) && $past(bit_cnt) == READ_START)
      else $error("data out enabled outside an addressed read");

   chk_crc_err_set: assert property (
      @(posedge clock) disable iff (sys_rst)
      crc_fail |=> crc_err ##1 (crc_err || $past(rb_load)))
      else $error("checksum failure not latched");

   chk_crc_read_clr: assert property (
      @(posedge clock) disable iff (sys_rst)
      (rb_load && !crc_fail) |=> !crc_err ##1 (alarm_n_oe == any_fault ||
                                               $past(hw_mode, 2)))
      else $error("read did not clear checksum error");

   chk_bad_frame_kept: assert property (
      @(posedge clock) disable iff (sys_rst)
      crc_fail |=> $stable(range_q) && $stable(output_on_q))
      else $error("register written by a failing frame");

   chk_write_cause: assert property (
      @(posedge clock) disable iff (sys_rst)
      !$stable(range_q) |-> $past(do_apply))
      else $error("range changed without an accepted frame");

   chk_soft_reset_off: assert property (
      @(posedge clock) disable iff (sys_rst)
      soft_rst |=> !output_on_q ##1 (drive.output_on == hw_mode))
      else $error("software reset left outputs on");

   chk_out_enable: assert property (
      @(posedge clock) disable iff (sys_rst)
      drive.output_on |-> $past(hw_mode || output_on_q))
      else $error("output enabled without output-on bit");

   chk_sw_alarm: assert property (
      @(posedge clock) disable iff (sys_rst)
      (!hw_mode && flt_s.volt_short) [*2] |->
         alarm_n_oe && !volt_short_alarm_n_oe)
      else $error("software mode alarm not asserted on fault");

   chk_hw_range: assert property (
      @(posedge clock) disable iff (sys_rst)
      hw_mode |=> drive.range == dcr_decode($past(sense_resistor_select_pin), $past(rng_pin)))
      else $error("strap mode range not taken from pins");

endmodule
`default_nettype wire

// >>> testbench/dcr_host_model.sv
`timescale 1ns/100ps
`default_nettype none
module dcr_host_model (
   input  wire logic clock,
   output logic      sclk_pin,
   output logic      frame_sync_n_pin,
   output logic      sdi_pin,
   input  wire logic sdo_out,
   input  wire logic sdo_oe
);
   logic sdo_last;
   wire  sdo_line;

   // a released data out shows the inverse of its last level
   assign sdo_line = sdo_oe ? sdo_out : ~sdo_last;

   initial begin
      sclk_pin = 1'b0;
      frame_sync_n_pin = 1'b1;
      sdi_pin = 1'b0;
      sdo_last = 1'b0;
   end

   always @(posedge clock) begin
      if (sdo_oe) begin
         sdo_last <= sdo_out;
      end
   end

   // one frame, msb first from bit 23; sclk runs only inside the frame
   task automatic xfer(input logic [23:0] w, input int n,
                       output logic [15:0] rd);
      rd = 16'h0000;
      @(posedge clock);
      frame_sync_n_pin <= 1'b0;
      repeat (8) @(posedge clock);
      for (int i = 0; i < n; i++) begin
         sclk_pin <= 1'b0;
         sdi_pin <= w[23-i];
         repeat (8) @(posedge clock);
         sclk_pin <= 1'b1;
         repeat (8) @(posedge clock);
         if (i >= 4) begin
            rd = {rd[14:0], sdo_line};
         end
      end
      sclk_pin <= 1'b0;
      repeat (8) @(posedge clock);
      frame_sync_n_pin <= 1'b1;
      sdi_pin <= ~sdi_pin;
      repeat (6) @(posedge clock);
   endtask
endmodule
`default_nettype wire

// >>> testbench/driver_config_readback_fault_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define DCR_CHECK(got, exp) \
   begin \
      num_checks++; \
      if ((got) !== (exp)) begin \
         miscompares++; \
         $display("[FAIL] t=%0t got=%h exp=%h", $time, (got), (exp)); \
      end \
   end
module driver_config_readback_fault_tb_top;
   import dcr_pkg::*;
   logic        clock = 1'b0;
   logic        sys_rst = 1'b1;
   wire         sclk_pin;
   wire         frame_sync_n_pin;
   wire         sdi_pin;
   wire         sdo_out;
   wire         sdo_oe;
   logic [2:0]  addr_strap = 3'h5;
   logic        pin_strap_mode = 1'b0;
   logic [3:0]  range_code_pins = 4'h0;
   logic        sense_resistor_pin = 1'b0;
   dcr_fault_t  fault_in = '0;
   dcr_drive_t  drive;
   wire         alarm_n_oe;
   wire         lo_oe;
   wire         vs_oe;
   wire         tp_oe;
   wire         alarm_line;
   wire  [2:0]  hw_lines;
   int          miscompares = 0;
   int          num_checks = 0;
   int          clr_seen = 0;
   logic [15:0] rd;
   dcr_range_t  exp_r [3] = '{RNG_I3P92_20P4, RNG_I0_20P4, RNG_I0_24P5};

   // open-drain pins with pull-ups
   assign alarm_line = ~alarm_n_oe;
   assign hw_lines = ~{tp_oe, lo_oe, vs_oe};

   always #5 clock = ~clock;

   // counts software clear pulses seen on the drive bus
   always @(posedge clock) begin
      if (drive.clear_pulse === 1'b1) begin
         clr_seen <= clr_seen + 1;
      end
   end

   dcr_host_model host_u (.clock(clock), .sclk_pin(sclk_pin),
      .frame_sync_n_pin(frame_sync_n_pin), .sdi_pin(sdi_pin),
      .sdo_out(sdo_out), .sdo_oe(sdo_oe));

   dcr_driver_config dut_u (.clock(clock), .sys_rst(sys_rst),
      .sclk_pin(sclk_pin), .frame_sync_n_pin(frame_sync_n_pin),
      .sdi_pin(sdi_pin), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
      .addr_strap(addr_strap), .pin_strap_mode(pin_strap_mode),
      .range_code_pins(range_code_pins),
      .sense_resistor_pin(sense_resistor_pin), .fault_in(fault_in),
      .drive(drive), .alarm_n_out(), .alarm_n_oe(alarm_n_oe),
      .loop_open_alarm_n_out(), .loop_open_alarm_n_oe(lo_oe),
      .volt_short_alarm_n_out(), .volt_short_alarm_n_oe(vs_oe),
      .temp_alarm_n_out(), .temp_alarm_n_oe(tp_oe));

   function automatic logic [7:0] crc8(input logic [15:0] d);
      logic [7:0] c;
      logic       fb;
      c = 8'h00;
      for (int i = 15; i >= 0; i--) begin
         fb = c[7] ^ d[i];
         c = {c[6:0], 1'b0} ^ (fb ? 8'h07 : 8'h00);
      end
      return c;
   endfunction

   function automatic logic [15:0] wr_word(input logic [2:0] a,
      input logic [3:0] r, input logic cs, on, rs, sr);
      return {a, 2'b00, r, cs, on, rs, 1'b0, sr, 2'b00};
   endfunction

   function automatic logic [15:0] exp_word(input logic [3:0] r,
      input logic cs, on, rs, input logic [3:0] st);
      return {addr_strap, 2'b10, r, cs, on, rs, st};
   endfunction

   task automatic wr(input logic [15:0] w, input logic crc, bad);
      logic [15:0] d;
      if (crc) begin
         host_u.xfer({w, crc8(w) ^ {7'h00, bad}}, 24, d);
      end else begin
         host_u.xfer({w, 8'h00}, 16, d);
      end
      repeat (4) @(posedge clock);
   endtask

   task automatic rd_chk(input logic [15:0] exp);
      `DCR_CHECK(sdo_oe, 1'b0)
      host_u.xfer({addr_strap, 1'b1, 20'h00000}, 20, rd);
      `DCR_CHECK(rd, exp)
      repeat (4) @(posedge clock);
      `DCR_CHECK(sdo_oe, 1'b0)
   endtask

   task automatic t_reset;
      `DCR_CHECK(drive.output_on, 1'b0)
      `DCR_CHECK(alarm_line, 1'b1)
      rd_chk(exp_word(4'h0, 1'b0, 1'b0, 1'b0, 4'h0));
   endtask

   task automatic t_ranges;
      for (int i = 0; i < 3; i++) begin
         wr(wr_word(3'h5, 4'hD + i[3:0], i[0], 1'b1, 1'b1, 1'b0),
            1'b0, 1'b0);
         `DCR_CHECK(drive.range, exp_r[i])
         `DCR_CHECK(drive.internal_res, 1'b1)
         `DCR_CHECK(drive.output_on, 1'b1)
         `DCR_CHECK(drive.clear_mid, i[0])
         rd_chk(exp_word(4'hD + i[3:0], i[0], 1'b1, 1'b1, 4'h0));
      end
      wr(wr_word(3'h5, 4'hE, 1'b0, 1'b1, 1'b0, 1'b0), 1'b0, 1'b0);
      `DCR_CHECK(drive.range, RNG_V0_40)
      wr(wr_word(3'h2, 4'h0, 1'b0, 1'b0, 1'b0, 1'b0), 1'b0, 1'b0);
      `DCR_CHECK(drive.range, RNG_V0_40)
      `DCR_CHECK(drive.output_on, 1'b1)
   endtask

   task automatic t_crc;
      wr(wr_word(3'h5, 4'h1, 1'b0, 1'b1, 1'b0, 1'b0), 1'b1, 1'b0);
      `DCR_CHECK(drive.range, RNG_I0_20)
      `DCR_CHECK(alarm_line, 1'b1)
      wr(wr_word(3'h5, 4'h2, 1'b0, 1'b1, 1'b0, 1'b0), 1'b1, 1'b1);
      `DCR_CHECK(drive.range, RNG_I0_20)
      `DCR_CHECK(alarm_line, 1'b0)
      rd_chk(exp_word(4'h1, 1'b0, 1'b1, 1'b0, 4'h8));
      `DCR_CHECK(alarm_line, 1'b1)
      rd_chk(exp_word(4'h1, 1'b0, 1'b1, 1'b0, 4'h0));
   endtask

   task automatic t_faults;
      for (int i = 0; i < 3; i++) begin
         @(posedge clock);
         fault_in <= dcr_fault_t'(3'h1 << i);
         repeat (6) @(posedge clock);
         `DCR_CHECK(alarm_line, 1'b0)
         rd_chk(exp_word(4'h1, 1'b0, 1'b1, 1'b0, 4'h1 << i));
         fault_in <= '0;
         repeat (6) @(posedge clock);
         `DCR_CHECK(alarm_line, 1'b1)
      end
   endtask

   task automatic t_srst;
      wr(wr_word(3'h5, 4'h1, 1'b1, 1'b1, 1'b0, 1'b0) |
         (16'h0001 << WB_CLEAR), 1'b0, 1'b0);
      `DCR_CHECK(clr_seen, 1)
      `DCR_CHECK(drive.clear_mid, 1'b1)
      wr(wr_word(3'h5, 4'h6, 1'b1, 1'b1, 1'b1, 1'b1), 1'b0, 1'b0);
      `DCR_CHECK(drive.output_on, 1'b0)
      rd_chk(exp_word(4'h0, 1'b0, 1'b0, 1'b0, 4'h0));
   endtask

   task automatic t_hw;
      @(posedge clock);
      pin_strap_mode <= 1'b1;
      range_code_pins <= 4'hF;
      sense_resistor_pin <= 1'b1;
      repeat (8) @(posedge clock);
      `DCR_CHECK(drive.range, RNG_I0_24P5)
      `DCR_CHECK(drive.output_on, 1'b1)
      wr(wr_word(3'h5, 4'h1, 1'b0, 1'b1, 1'b0, 1'b0), 1'b0, 1'b0);
      `DCR_CHECK(drive.range, RNG_I0_24P5)
      for (int i = 0; i < 3; i++) begin
         fault_in <= dcr_fault_t'(3'h1 << i);
         repeat (6) @(posedge clock);
         `DCR_CHECK(hw_lines, ~(3'h1 << i))
         `DCR_CHECK(alarm_line, 1'b1)
      end
   endtask

   task automatic final_report;
      $display("checks %0d mismatches %0d", num_checks, miscompares);
      if (miscompares == 0 && num_checks > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask

   initial begin
      repeat (60000) @(posedge clock);
      miscompares++;
      final_report();
   end

   initial begin
      repeat (3) @(posedge clock);
      sys_rst <= 1'b0;
      repeat (6) @(posedge clock);
      t_reset();
      t_ranges();
      t_crc();
      t_faults();
      t_srst();
      t_hw();
      final_report();
   end
endmodule
`default_nettype wire
